// ==== core/ssr_pkg.sv ====
// shared constants and types for the sensor serial read and resync port
package ssr_pkg;

	////////////////////////////////////////////////////////////////////////
	// clocks and timing
	localparam int SYS_CLK_HZ = 100_000_000;
	localparam int SYS_CLK_MHZ = SYS_CLK_HZ / 1_000_000;
	localparam int SCLK_MAX_HZ = 10_000_000;
	localparam int SCLK_HALF_CYC =
		(SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
	localparam int FRAME_RATE_HZ = 3000;
	localparam int FRAME_CYC = SYS_CLK_HZ / FRAME_RATE_HZ;
	localparam int PD_MAX_FRAMES = 2;
	localparam int PD_MAX_CYC = PD_MAX_FRAMES * FRAME_CYC;
	localparam int RESYNC_LOW_NS = 1000;
	localparam int RESYNC_CYC = (RESYNC_LOW_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int WDT_TIMEOUT_US = 1700;
	localparam int WDT_CYC = WDT_TIMEOUT_US * SYS_CLK_MHZ;
	localparam int PU_WAIT_US = 3000;
	localparam int PU_CYC = PU_WAIT_US * SYS_CLK_MHZ;
	localparam int SYNC_MARGIN = 4;

	////////////////////////////////////////////////////////////////////////
	// frame layout
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int XFER_BITS = 16;
	localparam int DIR_BIT = 7;
	localparam int PD_BIT = 6;
	localparam logic DIR_READ = 1'b0;
	localparam logic DIR_WRITE = 1'b1;
	localparam logic [4:0] ADDR_LAST = 5'h07;
	localparam logic [4:0] DATA_FIRST = 5'h08;
	localparam logic [4:0] XFER_LAST = 5'h0F;

	////////////////////////////////////////////////////////////////////////
	// register addresses and values
	localparam logic [6:0] PROD_ID_ADDR = 7'h00;
	localparam logic [6:0] OP_CFG_ADDR = 7'h0A;
	localparam logic [7:0] OP_CFG_RST = 8'h00;
	// identification value is arbitrary
	localparam logic [7:0] PROD_ID_VAL = 8'h5A;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SHIFT = 3'b001,
		ST_WAIT = 3'b010,
		ST_RS_LO = 3'b011,
		ST_RS_HI = 3'b100
	} ssr_host_st_t;

endpackage

// ==== core/ssr_link_if.sv ====
// two-wire link between serial host and sensor
`timescale 1ns/1ps
interface ssr_link_if;
	logic sclk;
	logic sdio_host_do;
	logic sdio_host_oe;
	logic sdio_dev_do;
	logic sdio_dev_oe;
	logic sdio;

	// resolved data wire; a weak pull-up holds it high when nobody drives
	assign sdio = sdio_dev_oe ? sdio_dev_do :
		(sdio_host_oe ? sdio_host_do : 1'b1);

	modport dev (
		input sclk,
		input sdio,
		output sdio_dev_do,
		output sdio_dev_oe
	);

	modport host (
		output sclk,
		output sdio_host_do,
		output sdio_host_oe,
		input sdio
	);
endinterface

// ==== core/ssr_sensor_port.sv ====
// sensor end of the two-wire serial register port
`timescale 1ns/1ps
// Contract
// - host starts reads: address byte, data byte
// - read address byte has top bit 0
// - change data on falling, sample on rising
// - host releases data after last address bit
// - sensor drives after falling past address
// - sensor releases on rising after last bit
// - sensor drives only in read data phase
// - host redrives after release, avoids floating
// - host resync: clock low, then long high
// - watchdog resets port, keeps registers
// - watchdog disabled while powered down
// - power-down bit set enters within two frames
// - clearing power-down bit leaves power-down
// - serial access works while powered down
// - host waits after wake before access, except after a verified write
// - host verifies writes by reading back
// - host checks sync via product id
// - write address byte has top bit 1
// - power-down bit is bit six of config
module ssr_sensor_port #(
	parameter int WDT_CYC = ssr_pkg::WDT_CYC,
	parameter int FRAME_CYC = ssr_pkg::FRAME_CYC,
	parameter int RESYNC_CYC = ssr_pkg::RESYNC_CYC,
	parameter logic [7:0] PROD_ID = ssr_pkg::PROD_ID_VAL
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	ssr_link_if.dev link,
	output logic power_down_o,
	output logic resync_o
);
	import ssr_pkg::*;

	localparam int HW = $clog2(WDT_CYC + 1);
	localparam int LW = $clog2(RESYNC_CYC + 1);
	localparam int FW = $clog2(FRAME_CYC + 1);
	localparam int DEPTH = 2 ** ADDR_W;

	// system clock side
	logic rst_q;
	logic port_clr;
	logic sclk_m;
	logic sclk_s;
	logic pd_m;
	logic pd_s;
	logic armed;
	logic fire;
	logic frame_tick;
	logic power_down;
	logic [LW-1:0] low_cnt;
	logic [HW-1:0] high_cnt;
	logic [FW-1:0] frame_cnt;

	// link clock side
	logic [4:0] bit_cnt;
	logic [7:0] shift_in;
	logic [7:0] addr_q;
	logic [7:0] tx;
	logic drv_on;
	logic [7:0] op_cfg;
	logic [7:0] rd_byte;
	logic [7:0] wr_byte;
	logic wr_commit;
	logic [7:0] mem [DEPTH];

	////////////////////////////////////////////////////////////////////////
	// synchronisers into the system clock

	always_ff @(posedge clk_sys_i) begin
		sclk_m <= link.sclk;
		sclk_s <= sclk_m;
	end

	// config bit crosses as a level; it only changes on a write commit or a system reset
	always_ff @(posedge clk_sys_i) begin
		pd_m <= op_cfg[PD_BIT];
		pd_s <= pd_m;
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog: a long low pulse arms, a long high after it fires

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || sclk_s) begin
			low_cnt <= '0;
		end else if (low_cnt != LW'(RESYNC_CYC)) begin
			low_cnt <= low_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || power_down || fire) begin
			armed <= 1'b0;
		end else if (low_cnt == LW'(RESYNC_CYC)) begin
			armed <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !sclk_s || !armed) begin
			high_cnt <= '0;
		end else if (!fire) begin
			high_cnt <= high_cnt + 1'b1;
		end
	end

	// no resync while powered down, the port stays as it is
	assign fire = armed && sclk_s && !power_down &&
		(high_cnt == HW'(WDT_CYC - 1));

	// clear pulse lands while the link clock rests high, so no edge races it
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rst_q <= 1'b1;
			port_clr <= 1'b1;
			resync_o <= 1'b0;
		end else begin
			rst_q <= 1'b0;
			port_clr <= fire;
			resync_o <= fire;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame timer and power-down state

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || frame_tick) begin
			frame_cnt <= '0;
		end else begin
			frame_cnt <= frame_cnt + 1'b1;
		end
	end

	assign frame_tick = (frame_cnt == FW'(FRAME_CYC - 1));

	// sync plus at most one frame keeps entry under two frames
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			power_down <= 1'b0;
		end else if (frame_tick) begin
			power_down <= pd_s;
		end
	end

	assign power_down_o = power_down;

	////////////////////////////////////////////////////////////////////////
	// receive side: sample on every rising link clock edge

	always_ff @(posedge link.sclk or posedge port_clr) begin
		if (port_clr) begin
			bit_cnt <= '0;
			shift_in <= '0;
			addr_q <= '0;
		end else begin
			shift_in <= {shift_in[6:0], link.sdio};
			if (bit_cnt == XFER_LAST) begin
				bit_cnt <= '0;
			end else begin
				bit_cnt <= bit_cnt + 1'b1;
			end
			if (bit_cnt == ADDR_LAST) begin
				addr_q <= {shift_in[6:0], link.sdio};
			end
		end
	end

	assign wr_byte = {shift_in[6:0], link.sdio};
	assign wr_commit = (bit_cnt == XFER_LAST) &&
		(addr_q[DIR_BIT] == DIR_WRITE);

	////////////////////////////////////////////////////////////////////////
	// registers; contents survive a watchdog resync

	// writes keep working in power-down, nothing here looks at it
	always_ff @(posedge link.sclk or posedge rst_q) begin
		if (rst_q) begin
			op_cfg <= OP_CFG_RST;
		end else if (wr_commit && addr_q[6:0] == OP_CFG_ADDR) begin
			op_cfg <= wr_byte;
		end
	end

	// scratch store for the rest of the map; not cleared by any reset
	always_ff @(posedge link.sclk) begin
		if (wr_commit) begin
			mem[addr_q[6:0]] <= wr_byte;
		end
	end

	always_comb begin
		if (addr_q[6:0] == PROD_ID_ADDR) begin
			rd_byte = PROD_ID;
		end else if (addr_q[6:0] == OP_CFG_ADDR) begin
			rd_byte = op_cfg;
		end else begin
			rd_byte = mem[addr_q[6:0]];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit side: change data on falling edges in read data phase

	always_ff @(negedge link.sclk or posedge port_clr) begin
		if (port_clr) begin
			drv_on <= 1'b0;
			tx <= '0;
		end else if (bit_cnt == DATA_FIRST &&
			addr_q[DIR_BIT] == DIR_READ) begin
			drv_on <= 1'b1;
			tx <= rd_byte;
		end else begin
			tx <= {tx[6:0], 1'b0};
			if (bit_cnt == '0) begin
				drv_on <= 1'b0;
			end
		end
	end

	// the counter wraps on the rising edge after the last data bit,
	// which drops the enable there without waiting for a falling edge
	assign link.sdio_dev_oe = drv_on && (bit_cnt != '0);
	assign link.sdio_dev_do = tx[7];

endmodule

// ==== core/ssr_host_port.sv ====
// host end: drives the serial clock and runs transfers and resync
`timescale 1ns/1ps
module ssr_host_port #(
	parameter int HALF_CYC = ssr_pkg::SCLK_HALF_CYC,
	parameter int RESYNC_CYC = ssr_pkg::RESYNC_CYC,
	parameter int WDT_CYC = ssr_pkg::WDT_CYC,
	parameter int PU_CYC = ssr_pkg::PU_CYC,
	parameter logic [7:0] EXP_ID = ssr_pkg::PROD_ID_VAL
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	ssr_link_if.host link,
	input wire logic req_i,
	input wire logic wr_i,
	input wire logic verify_i,
	input wire logic resync_i,
	input wire logic [ssr_pkg::ADDR_W-1:0] addr_i,
	input wire logic [ssr_pkg::DATA_W-1:0] wdata_i,
	output logic busy_o,
	output logic done_o,
	output logic err_o,
	output logic [ssr_pkg::DATA_W-1:0] rdata_o
);
	import ssr_pkg::*;

	localparam int CW = $clog2(WDT_CYC + PU_CYC + RESYNC_CYC +
		SYNC_MARGIN + HALF_CYC + 1);

	ssr_host_st_t state;
	logic [CW-1:0] wcnt;
	logic [CW-1:0] wlim;
	logic [4:0] bit_idx;
	logic sclk;
	logic oe;
	logic [15:0] tx;
	logic [7:0] rx;
	logic [7:0] rx_byte;
	logic [6:0] cur_addr;
	logic [7:0] wdata_q;
	logic cur_wr;
	logic do_verify;
	logic pend_rb;
	logic readback;
	logic err_q;
	logic sdio_m;
	logic sdio_s;

	function automatic logic [15:0] frame(input logic wr,
		input logic [6:0] addr, input logic [7:0] data);
		frame = {wr, addr, data};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// data pin back from the sensor

	always_ff @(posedge clk_sys_i) begin
		sdio_m <= link.sdio;
		sdio_s <= sdio_m;
	end

	assign rx_byte = {rx[6:0], sdio_s};

	////////////////////////////////////////////////////////////////////////
	// transfer sequencer

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state <= ST_IDLE;
			sclk <= 1'b1;
			oe <= 1'b1;
			tx <= '1;
			rx <= '0;
			bit_idx <= '0;
			wcnt <= '0;
			wlim <= '0;
			cur_wr <= 1'b0;
			cur_addr <= '0;
			wdata_q <= '0;
			do_verify <= 1'b0;
			pend_rb <= 1'b0;
			readback <= 1'b0;
			err_q <= 1'b0;
			done_o <= 1'b0;
			err_o <= 1'b0;
			rdata_o <= '0;
		end else begin
			done_o <= 1'b0;
			err_o <= 1'b0;
			case (state)
			ST_IDLE: begin
				oe <= 1'b1;
				wcnt <= '0;
				if (resync_i) begin
					sclk <= 1'b0;
					wlim <= CW'(RESYNC_CYC + SYNC_MARGIN - 1);
					state <= ST_RS_LO;
				end else if (req_i) begin
					cur_wr <= wr_i;
					cur_addr <= addr_i;
					wdata_q <= wdata_i;
					do_verify <= wr_i && verify_i;
					readback <= 1'b0;
					tx <= frame(wr_i, addr_i, wdata_i);
					sclk <= 1'b0;
					bit_idx <= '0;
					wlim <= CW'(HALF_CYC - 1);
					state <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (wcnt != wlim) begin
					wcnt <= wcnt + 1'b1;
					// let go a cycle after the rising edge; the sensor
					// samples the last address bit on that very edge
					if (sclk && bit_idx == ADDR_LAST && !cur_wr) begin
						oe <= 1'b0;
					end
				end else begin
					wcnt <= '0;
					if (!sclk) begin
						sclk <= 1'b1;
						rx <= rx_byte;
						if (bit_idx == XFER_LAST) begin
							state <= ST_WAIT;
							wlim <= CW'(HALF_CYC - 1);
							err_q <= 1'b0;
							if (!cur_wr) begin
								rdata_o <= rx_byte;
							end
							if (readback) begin
								err_q <= (rx_byte != wdata_q);
							end else if (!cur_wr &&
								cur_addr == PROD_ID_ADDR) begin
								err_q <= (rx_byte != EXP_ID);
							end
							if (do_verify) begin
								do_verify <= 1'b0;
								pend_rb <= 1'b1;
							end else if (cur_wr &&
								cur_addr == OP_CFG_ADDR &&
								!wdata_q[PD_BIT]) begin
								wlim <= CW'(PU_CYC - 1);
							end
						end
					end else begin
						sclk <= 1'b0;
						bit_idx <= bit_idx + 1'b1;
						tx <= {tx[14:0], 1'b1};
					end
				end
			end
			ST_WAIT: begin
				// one cycle after the sensor let go, so no overlap
				oe <= 1'b1;
				// idle level only after the last bit has been sampled
				tx <= '1;
				if (wcnt != wlim) begin
					wcnt <= wcnt + 1'b1;
				end else begin
					wcnt <= '0;
					if (pend_rb) begin
						pend_rb <= 1'b0;
						readback <= 1'b1;
						cur_wr <= 1'b0;
						tx <= frame(DIR_READ, cur_addr, wdata_q);
						sclk <= 1'b0;
						bit_idx <= '0;
						wlim <= CW'(HALF_CYC - 1);
						state <= ST_SHIFT;
					end else begin
						done_o <= 1'b1;
						err_o <= err_q;
						readback <= 1'b0;
						state <= ST_IDLE;
					end
				end
			end
			ST_RS_LO: begin
				if (wcnt != wlim) begin
					wcnt <= wcnt + 1'b1;
				end else begin
					wcnt <= '0;
					sclk <= 1'b1;
					wlim <= CW'(WDT_CYC + SYNC_MARGIN - 1);
					state <= ST_RS_HI;
				end
			end
			ST_RS_HI: begin
				if (wcnt != wlim) begin
					wcnt <= wcnt + 1'b1;
				end else begin
					wcnt <= '0;
					done_o <= 1'b1;
					state <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	assign busy_o = (state != ST_IDLE);
	assign link.sclk = sclk;
	assign link.sdio_host_do = tx[15];
	assign link.sdio_host_oe = oe;

endmodule

// ==== testbench/ssr_link_asserts.sv ====
// link checker for the serial host and sensor ends
`timescale 1ns/1ps
module ssr_link_asserts #(
	parameter int HALF_CYC = 5
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic sclk,
	input wire logic sdio_host_do,
	input wire logic sdio_host_oe,
	input wire logic sdio_dev_do,
	input wire logic sdio_dev_oe,
	input wire logic sdio
);
	logic sclk_q;
	logic dir_q;
	logic [3:0] rise_cnt;
	logic [7:0] low_cnt;
	logic [7:0] drv_cnt;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	////////////////////////////////////////
	always_ff @(posedge clk_sys_i) begin
		sclk_q <= sclk;
	end
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || sclk) begin
			low_cnt <= 8'h00;
		end else if (low_cnt != 8'hFF) begin
			low_cnt <= low_cnt + 8'h01;
		end
	end
	// a long low phase is a resync, so the bit count starts over
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || low_cnt >= 8'(3 * HALF_CYC)) begin
			rise_cnt <= 4'h0;
		end else if (sclk && !sclk_q) begin
			rise_cnt <= rise_cnt + 4'h1;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (sclk && !sclk_q && rise_cnt == 4'h0) begin
			dir_q <= sdio;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !sdio_dev_oe) begin
			drv_cnt <= 8'h00;
		end else begin
			drv_cnt <= drv_cnt + 8'h01;
		end
	end
	////////////////////////////////////////
	no_collision_a: assert property (
		!(sdio_dev_oe && sdio_host_oe))
		else $error("both ends drive the data line");
	dev_edge_a: assert property (
		sdio_dev_oe && $past(sdio_dev_oe) && $changed(sdio_dev_do)
		|-> $fell(sclk))
		else $error("sensor data changed off a falling edge");
	host_edge_a: assert property (
		sdio_host_oe && $changed(sdio_host_do) |-> !$rose(sclk))
		else $error("host data changed on a rising edge");
	host_rel_a: assert property (
		$fell(sdio_host_oe) |-> sclk && $past(sclk) &&
		!$past(sclk, 2) && rise_cnt == 4'h8)
		else $error("host released the line at the wrong bit");
	turnaround_a: assert property (
		$fell(sdio_host_oe) |-> !sdio_dev_oe ##[3:8] sdio_dev_oe)
		else $error("sensor did not take over after turnaround");
	drive_start_a: assert property (
		$rose(sdio_dev_oe) |-> $fell(sclk) && rise_cnt == 4'h8 &&
		dir_q == 1'b0)
		else $error("sensor drove outside a read data phase");
	drive_stop_a: assert property (
		$fell(sdio_dev_oe) |-> $rose(sclk) && rise_cnt == 4'hF)
		else $error("sensor released off the last rising edge");
	drive_len_a: assert property (
		$fell(sdio_dev_oe) |-> drv_cnt == 8'(15 * HALF_CYC))
		else $error("sensor drive span is not eight bits");
	host_back_a: assert property (
		$fell(sdio_dev_oe) |-> ##[1:3] sdio_host_oe)
		else $error("host left the line floating");
	read_c: cover property ($fell(sdio_dev_oe));
	write_c: cover property (sclk && !sclk_q && rise_cnt == 4'hF && dir_q);
	resync_c: cover property (low_cnt == 8'(3 * HALF_CYC));
endmodule

// ==== testbench/testbench.sv ====
// bench joining host and sensor ends over one link
`timescale 1ns/1ps
module testbench;
	import ssr_pkg::*;
	localparam int WDT = 200;
	localparam int FRM = 50;
	logic clk_sys_i = 1'b0;
	logic srst = 1'b1;
	logic hrst = 1'b0;
	logic host_rst;
	logic req = 1'b0;
	logic wr = 1'b0;
	logic verify = 1'b0;
	logic resync = 1'b0;
	logic [6:0] addr = 7'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic busy, done, err, pd, rs_pulse, err_s;
	int errors = 0;
	int cmp_count = 0;
	int rs_cnt = 0;
	int rs0;
	// host reset alone knocks the two ends out of step
	assign host_rst = srst | hrst;
	ssr_link_if link();
	ssr_sensor_port #(.WDT_CYC(WDT), .FRAME_CYC(FRM), .RESYNC_CYC(20))
		i_ssr_sensor_port (.clk_sys_i(clk_sys_i), .srst_i(srst),
		.link(link), .power_down_o(pd), .resync_o(rs_pulse));
	ssr_host_port #(.HALF_CYC(5), .RESYNC_CYC(20), .WDT_CYC(WDT),
		.PU_CYC(30)) i_ssr_host_port (.clk_sys_i(clk_sys_i),
		.srst_i(host_rst), .link(link), .req_i(req), .wr_i(wr),
		.verify_i(verify), .resync_i(resync), .addr_i(addr),
		.wdata_i(wdata), .busy_o(busy), .done_o(done), .err_o(err),
		.rdata_o(rdata));
	ssr_link_asserts #(.HALF_CYC(5)) i_ssr_link_asserts (
		.clk_sys_i(clk_sys_i), .srst_i(host_rst), .sclk(link.sclk),
		.sdio_host_do(link.sdio_host_do),
		.sdio_host_oe(link.sdio_host_oe),
		.sdio_dev_do(link.sdio_dev_do), .sdio_dev_oe(link.sdio_dev_oe),
		.sdio(link.sdio));
	////////////////////////////////////////
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		if (rs_pulse === 1'b1) begin
			rs_cnt++;
		end
	end
	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	// cut > 0 resets the host that many cycles into the transfer
	task automatic xfer(input logic w, input logic v, input logic rq,
		input logic [6:0] a, input logic [7:0] d, input int cut);
		int n;
		n = 0;
		@(negedge clk_sys_i);
		req = ~rq;
		resync = rq;
		wr = w;
		verify = v;
		addr = a;
		wdata = d;
		@(negedge clk_sys_i);
		req = 1'b0;
		resync = 1'b0;
		chk("busy_on", {7'h00, busy}, 8'h01);
		if (cut > 0) begin
			repeat (cut) @(negedge clk_sys_i);
			hrst = 1'b1;
			repeat (2) @(negedge clk_sys_i);
			hrst = 1'b0;
		end else begin
			while (done !== 1'b1 && n < 4000) begin
				@(negedge clk_sys_i);
				n++;
			end
			err_s = err;
			chk("done", {7'h00, done}, 8'h01);
			chk("busy", {7'h00, busy}, 8'h00);
		end
	endtask
	task automatic wait_pd(input logic exp, input int lim);
		int n;
		n = 0;
		while (pd !== exp && n < lim) begin
			@(negedge clk_sys_i);
			n++;
		end
		chk("power_down", {7'h00, pd}, {7'h00, exp});
	endtask
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		srst = 1'b0;
		xfer(0, 0, 0, PROD_ID_ADDR, 8'h00, 0);
		chk("id", rdata, PROD_ID_VAL);
		chk("id_err", {7'h00, err_s}, 8'h00);
		$display("test id read done");
		for (int i = 0; i < 2; i++) begin
			xfer(1, 1, 0, i != 0 ? 7'h7F : 7'h15,
				i != 0 ? 8'h3C : 8'hA5, 0);
			chk("verify_err", {7'h00, err_s}, 8'h00);
			xfer(0, 0, 0, i != 0 ? 7'h7F : 7'h15, 8'h00, 0);
			chk("readback", rdata, i != 0 ? 8'h3C : 8'hA5);
		end
		$display("test write readback done");
		rs0 = rs_cnt;
		xfer(0, 0, 0, PROD_ID_ADDR, 8'h00, 40);
		xfer(0, 0, 1, 7'h00, 8'h00, 0);
		repeat (4) @(negedge clk_sys_i);
		chk("resync", 8'(rs_cnt - rs0), 8'h01);
		xfer(0, 0, 0, PROD_ID_ADDR, 8'h00, 0);
		chk("id_after", rdata, PROD_ID_VAL);
		xfer(0, 0, 0, 7'h15, 8'h00, 0);
		chk("kept", rdata, 8'hA5);
		$display("test resync done");
		xfer(1, 0, 0, OP_CFG_ADDR, 8'h40, 0);
		wait_pd(1'b1, 2 * FRM - 8);
		xfer(0, 0, 0, OP_CFG_ADDR, 8'h00, 0);
		chk("cfg", rdata, 8'h40);
		xfer(1, 0, 0, OP_CFG_ADDR, 8'h00, 0);
		wait_pd(1'b0, 2 * FRM - 40);
		xfer(1, 0, 0, OP_CFG_ADDR, 8'h40, 0);
		wait_pd(1'b1, 2 * FRM - 8);
		rs0 = rs_cnt;
		xfer(0, 0, 1, 7'h00, 8'h00, 0);
		repeat (8) @(negedge clk_sys_i);
		chk("pd_resync", 8'(rs_cnt - rs0), 8'h00);
		$display("test power down done");
		final_report;
	end
	// the tests need about 3k cycles; allow several times that
	initial begin
		#300_000;
		errors++;
		final_report;
	end
endmodule
